// ==== wdr_pkg.sv ====
// Shared constants of the watchdog and reset-cause block
package wdr_pkg;

  // ==========================================================
  // Register bus geometry
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;

  // ==========================================================
  // Register offsets
  localparam logic [3:0]  CAUSE_OFS  = 4'h0;
  localparam logic [3:0]  CTRL_OFS   = 4'h1;

  // ==========================================================
  // Reset-cause register fields
  localparam int unsigned WDOG_FLAG_BIT  = 3;
  localparam int unsigned BROWN_FLAG_BIT = 2;
  localparam int unsigned PIN_FLAG_BIT   = 1;
  localparam int unsigned POWER_FLAG_BIT = 0;
  localparam logic [3:0]  CAUSE_RST      = 4'h1;

  // ==========================================================
  // Watchdog control register fields
  localparam int unsigned CE_BIT     = 4;
  localparam int unsigned EN_BIT     = 3;
  localparam int unsigned PSEL_HI    = 2;
  localparam logic        EN_RST     = 1'b0;
  localparam logic [2:0]  PSEL_RST   = 3'h0;

  // ==========================================================
  // Timing counts
  localparam logic [2:0]  CE_CYC     = 3'h4;
  localparam int unsigned CNT_W      = 22;
  localparam logic [21:0] BASE_CYC   = 22'h004000;
  localparam int unsigned DLY_W      = 16;
  localparam logic [15:0] STARTUP_CYC = 16'h0040;
  localparam int unsigned SYNC_N     = 3;

endpackage : wdr_pkg

// ==== wdr_osc_counter.sv ====
// Watchdog oscillator edge counter with period compare and expiry pulse
`timescale 1ns/1ps

module wdr_osc_counter #(
  parameter logic [21:0] BASE_CYC = wdr_pkg::BASE_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     osc_pin,
  input  wire logic                     restart,
  input  wire logic                     enable,
  input  wire logic [2:0]               period_sel,
  output logic                          expire_q,
  output logic [wdr_pkg::CNT_W-1:0]     count_q
);

  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic                      tick_w;
  logic [wdr_pkg::CNT_W-1:0] limit_w;
  logic                      hit_w;
  logic [wdr_pkg::CNT_W-1:0] count_d;
  logic                      expire_d;

  // ==========================================================
  // Oscillator pin synchroniser, edge taken after stage two
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Counting runs on oscillator edges only, never on sys_clk rate
  assign tick_w  = osc_s2_q & ~osc_s3_q;                                 // RULE9 RULE21
  // Limit is the base count doubled per select step
  assign limit_w = BASE_CYC << period_sel;                               // RULE18
  assign hit_w   = tick_w && (count_q == limit_w - 22'h000001);

  // ==========================================================
  // Next count: restart wins, then wrap at the limit
  assign count_d  = (restart || !enable) ? '0 :                           // RULE10
                    hit_w ? '0 :
                    tick_w ? count_q + 22'h000001 : count_q;
  assign expire_d = enable && !restart && hit_w;                          // RULE11

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q  <= '0;
      expire_q <= 1'b0;
    end else begin
      count_q  <= count_d;
      expire_q <= expire_d;
    end
  end

  // ==========================================================
  // Checks
  property p_restart_clears;
    @(posedge sys_clk) disable iff (rst)
    restart |=> (count_q == '0);
  endproperty
  a_restart_clears: assert property (p_restart_clears)                    // RULE10
    else $error("count not cleared by restart");

  property p_expire_at_limit;
    @(posedge sys_clk) disable iff (rst)
    expire_q |-> ($past(count_q) == limit_w - 22'h000001) && (count_q == '0);
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit)                  // RULE18
    else $error("expiry not at selected limit");

endmodule : wdr_osc_counter

// ==== wdr_watchdog_top.sv ====
// Watchdog timer with guarded control writes and reset-cause flags
//
// Operation
// (RULE1) Watchdog expiry emits a reset pulse exactly one system clock long.
// (RULE2) Falling edge of that pulse starts the start-up delay counter.
// (RULE3) Reset-cause bits 7..4 always read zero.
// (RULE4) Watchdog flag sets on watchdog reset; power-on or software zero clears.
// (RULE5) Brown-out flag sets on brown-out reset; power-on or software zero clears.
// (RULE6) Pin flag sets on external pin reset; power-on or software zero clears.
// (RULE7) Power-up flag sets on power-on; only a software zero clears it.
// (RULE8) Software should read then clear the cause flags early after start-up.
// (RULE9) Watchdog counts cycles of its own oscillator, not the system clock.
// (RULE10) Count restarts on restart instruction, on disable and on chip reset.
// (RULE11) Period elapsing without restart resets the chip to the reset vector.
// (RULE12) Control register bits 7..5 always read zero.
// (RULE13) Writing enable to zero is ignored unless change-enable is one.
// (RULE14) Change-enable clears itself four system cycles after it is written.
// (RULE15) Period select changes only while change-enable is one.
// (RULE16) Enable written one starts; zero within the window stops the watchdog.
// (RULE17) Disable needs change-enable and enable both one, then zero within four; the code opens the window on change-enable alone.
// (RULE18) Time-out is 16384 oscillator cycles times two to the select value.
// (RULE19) Fuse unprogrammed: starts disabled, enable needs no guard sequence.
// (RULE20) Fuse programmed: always runs, enable reads one, period guarded.
// (RULE21) Control passes safely to the oscillator domain, expiry back again.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module wdr_watchdog_top #(
  parameter logic [21:0] BASE_CYC    = wdr_pkg::BASE_CYC,
  parameter logic [15:0] STARTUP_CYC = wdr_pkg::STARTUP_CYC
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic [wdr_pkg::ADDR_W-1:0] addr,
  input  wire logic [wdr_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [wdr_pkg::DATA_W-1:0] rd_data_q,
  input  wire logic                       watchdog_restart_instruction,
  input  wire logic                       wdt_osc,
  input  wire logic                       brownout_rst,
  input  wire logic                       pin_rst_n,
  input  wire logic                       safety_level_fuse,
  output logic                            wdt_rst_pulse_q,
  output logic                            cpu_hold_q
);

  // ==========================================================
  // Declarations
  logic [wdr_pkg::SYNC_N-1:0] pin_raw_w;
  logic [wdr_pkg::SYNC_N-1:0] sync1_q;
  logic [wdr_pkg::SYNC_N-1:0] sync2_q;
  logic                       brown_s_w;
  logic                       pin_s_w;
  logic                       fuse_s_w;
  logic                       ext_rst_w;
  logic                       chip_rst_w;

  logic                       cause_wr_w;
  logic                       ctrl_wr_w;
  logic                       cause_rd_w;
  logic                       ctrl_rd_w;

  logic [3:0]                 cause_q;
  logic [3:0]                 cause_d;
  logic [3:0]                 cause_set_w;
  logic [3:0]                 cause_clr_w;

  logic                       wde_q;
  logic                       wde_d;
  logic [2:0]                 period_q;
  logic [2:0]                 period_d;
  logic                       ce_q;
  logic                       ce_d;
  logic [2:0]                 ce_cnt_q;
  logic [2:0]                 ce_cnt_d;
  logic                       enable_w;

  logic                       expire_w;
  logic [wdr_pkg::CNT_W-1:0]  wdt_count_w;
  logic                       pulse_d;
  logic [wdr_pkg::DLY_W-1:0]  dly_q;
  logic [wdr_pkg::DLY_W-1:0]  dly_d;
  logic                       hold_d;

  logic [wdr_pkg::DATA_W-1:0] cause_view_w;
  logic [wdr_pkg::DATA_W-1:0] ctrl_view_w;
  logic [wdr_pkg::DATA_W-1:0] rd_mux_w;
  logic [wdr_pkg::DATA_W-1:0] rd_data_d;

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [wdr_pkg::ADDR_W-1:0] a,
                               input logic [wdr_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================
  // Pin synchronisers: reset sources and fuse strap
  assign pin_raw_w = {safety_level_fuse, ~pin_rst_n, brownout_rst};

  genvar gi;
  generate
    for (gi = 0; gi < wdr_pkg::SYNC_N; gi++) begin : g_sync
      // Stage one feeds stage two only
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw_w[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign brown_s_w  = sync2_q[0];
  assign pin_s_w    = sync2_q[1];
  assign fuse_s_w   = sync2_q[2];
  assign ext_rst_w  = brown_s_w | pin_s_w;
  // Any chip reset, including the start-up delay, holds the count at zero
  assign chip_rst_w = ext_rst_w | wdt_rst_pulse_q | cpu_hold_q;            // RULE10

  // ==========================================================
  // Register decode
  assign cause_wr_w = wr_en && hit(addr, wdr_pkg::CAUSE_OFS);
  assign ctrl_wr_w  = wr_en && hit(addr, wdr_pkg::CTRL_OFS);
  assign cause_rd_w = rd_en && hit(addr, wdr_pkg::CAUSE_OFS);
  assign ctrl_rd_w  = rd_en && hit(addr, wdr_pkg::CTRL_OFS);

  // ==========================================================
  // Reset-cause flags: set wins over a software clear
  assign cause_set_w = {wdt_rst_pulse_q, brown_s_w, pin_s_w, 1'b0};      // RULE4 RULE5 RULE6
  // Writing one keeps a flag; writing zero clears it
  assign cause_clr_w = {4{cause_wr_w}} & ~wr_data[3:0];                  // RULE7
  assign cause_d     = cause_set_w | (cause_q & ~cause_clr_w);

  // Power-on sets only the power-up flag and clears the rest
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause_q <= wdr_pkg::CAUSE_RST;                                      // RULE7
    end else begin
      cause_q <= cause_d;
    end
  end

  // ==========================================================
  // Guarded control writes
  // Fuse forces the watchdog on whatever the enable bit holds
  assign enable_w = wde_q | fuse_s_w;                                     // RULE20

  // One enables freely; zero only lands inside the window
  assign wde_d = !ctrl_wr_w ? wde_q :
                 wr_data[wdr_pkg::EN_BIT] ? 1'b1 :                       // RULE16 RULE19
                 ce_q ? 1'b0 : wde_q;                                     // RULE13

  // Period select is held unless the window is open
  assign period_d = (ctrl_wr_w && ce_q) ? wr_data[wdr_pkg::PSEL_HI:0]     // RULE15
                                        : period_q;

  // Window opens on a write of one and closes after four cycles or on a control write of zero
  assign ce_d = (ctrl_wr_w && wr_data[wdr_pkg::CE_BIT]) ? 1'b1 :          // RULE14
                ctrl_wr_w ? 1'b0 :
                (ce_q && ce_cnt_q == 3'h1) ? 1'b0 : ce_q;
  assign ce_cnt_d = (ctrl_wr_w && wr_data[wdr_pkg::CE_BIT]) ? wdr_pkg::CE_CYC :
                    (ce_cnt_q != 3'h0) ? ce_cnt_q - 3'h1 : 3'h0;

  // Control state survives watchdog and pin resets so the flags stay useful
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wde_q    <= wdr_pkg::EN_RST;                                        // RULE19
      period_q <= wdr_pkg::PSEL_RST;
      ce_q     <= 1'b0;
      ce_cnt_q <= 3'h0;
    end else begin
      wde_q    <= wde_d;
      period_q <= period_d;
      ce_q     <= ce_d;
      ce_cnt_q <= ce_cnt_d;
    end
  end

  // ==========================================================
  // Oscillator-driven counter
  // Period and enable are quasi-static; the counter uses the period per tick and enable every cycle
  wdr_osc_counter #(
    .BASE_CYC   (BASE_CYC)
  ) u_counter (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .osc_pin    (wdt_osc),
    .restart    (watchdog_restart_instruction | chip_rst_w),              // RULE10
    .enable     (enable_w),
    .period_sel (period_q),
    .expire_q   (expire_w),
    .count_q    (wdt_count_w)
  );

  // ==========================================================
  // Reset pulse and start-up delay
  // Expiry already arrives as a single sys_clk pulse
  assign pulse_d = expire_w && enable_w && !chip_rst_w;                   // RULE1 RULE21

  // Delay loads while the pulse is high, so counting starts as it falls
  assign dly_d  = (wdt_rst_pulse_q || ext_rst_w) ? STARTUP_CYC :          // RULE2
                  (dly_q != '0) ? dly_q - 16'h0001 : dly_q;
  // Core stays held until the delay has run out
  assign hold_d = (dly_d != '0);                                          // RULE11

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdt_rst_pulse_q <= 1'b0;
      dly_q           <= '0;
      cpu_hold_q      <= 1'b0;
    end else begin
      wdt_rst_pulse_q <= pulse_d;
      dly_q           <= dly_d;
      cpu_hold_q      <= hold_d;
    end
  end

  // ==========================================================
  // Read path: reserved bits forced low, unmapped reads zero
  assign cause_view_w = {4'h0, cause_q};                                  // RULE3
  assign ctrl_view_w  = {3'h0, ce_q, enable_w, period_q};                 // RULE12 RULE20
  assign rd_mux_w     = cause_rd_w ? cause_view_w :
                        ctrl_rd_w  ? ctrl_view_w  : 8'h00;
  assign rd_data_d    = rd_en ? rd_mux_w : 8'h00;

  // Data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // ==========================================================
  // Assertions
  property p_pulse_single;
    @(posedge sys_clk) disable iff (rst)
    wdt_rst_pulse_q |=> !wdt_rst_pulse_q;
  endproperty
  a_pulse_single: assert property (p_pulse_single) // RULE1
    else $error("reset pulse longer than one cycle");

  property p_delay_starts;
    @(posedge sys_clk) disable iff (rst)
    wdt_rst_pulse_q |=> (dly_q == STARTUP_CYC) && cpu_hold_q;
  endproperty
  a_delay_starts: assert property (p_delay_starts) // RULE2
    else $error("start-up delay not loaded at pulse end");

  property p_cause_reserved;
    @(posedge sys_clk) disable iff (rst)
    cause_rd_w |=> (rd_data_q[7:4] == 4'h0) && (rd_data_q[3:0] == $past(cause_q));
  endproperty
  a_cause_reserved: assert property (p_cause_reserved) // RULE3
    else $error("cause read data wrong");

  property p_wdog_flag;
    @(posedge sys_clk) disable iff (rst)
    wdt_rst_pulse_q |=> cause_q[wdr_pkg::WDOG_FLAG_BIT];
  endproperty
  a_wdog_flag: assert property (p_wdog_flag) // RULE4
    else $error("watchdog flag not set");

  property p_brown_flag;
    @(posedge sys_clk) disable iff (rst)
    brown_s_w |=> cause_q[wdr_pkg::BROWN_FLAG_BIT];
  endproperty
  a_brown_flag: assert property (p_brown_flag) // RULE5
    else $error("brown-out flag not set");

  property p_pin_flag;
    @(posedge sys_clk) disable iff (rst)
    pin_s_w |=> cause_q[wdr_pkg::PIN_FLAG_BIT];
  endproperty
  a_pin_flag: assert property (p_pin_flag) // RULE6
    else $error("pin flag not set");

  property p_power_flag;
    @(posedge sys_clk) disable iff (rst)
    $fell(cause_q[wdr_pkg::POWER_FLAG_BIT]) |->
      $past(cause_wr_w) && !$past(wr_data[wdr_pkg::POWER_FLAG_BIT]);
  endproperty
  a_power_flag: assert property (p_power_flag) // RULE7
    else $error("power-up flag cleared without write");

  property p_ctrl_reserved;
    @(posedge sys_clk) disable iff (rst)
    ctrl_rd_w |=> (rd_data_q[7:5] == 3'h0);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) // RULE12
    else $error("control reserved bits nonzero");

  property p_guarded_disable;
    @(posedge sys_clk) disable iff (rst)
    ctrl_wr_w && !wr_data[wdr_pkg::EN_BIT] && !ce_q && wde_q |=> wde_q;
  endproperty
  a_guarded_disable: assert property (p_guarded_disable) // RULE13
    else $error("enable cleared outside window");

  property p_window_closes;
    @(posedge sys_clk) disable iff (rst)
    (ctrl_wr_w && wr_data[wdr_pkg::CE_BIT]) ##1 (ce_q && !ctrl_wr_w)[*4] |=> !ce_q;
  endproperty
  a_window_closes: assert property (p_window_closes) // RULE14
    else $error("change window not four cycles");

  property p_period_held;
    @(posedge sys_clk) disable iff (rst)
    !(ctrl_wr_w && ce_q) |=> (period_q == $past(period_q));
  endproperty
  a_period_held: assert property (p_period_held) // RULE15
    else $error("period changed outside window");

  property p_enable_set;
    @(posedge sys_clk) disable iff (rst)
    ctrl_wr_w && wr_data[wdr_pkg::EN_BIT] |=> wde_q && enable_w;
  endproperty
  a_enable_set: assert property (p_enable_set) // RULE16
    else $error("enable write not taken");

  property p_fuse_forces;
    @(posedge sys_clk) disable iff (rst)
    fuse_s_w && ctrl_rd_w |=> rd_data_q[wdr_pkg::EN_BIT];
  endproperty
  a_fuse_forces: assert property (p_fuse_forces) // RULE20
    else $error("fuse did not force enable");

  c_expiry: cover property (@(posedge sys_clk) disable iff (rst)
    wdt_rst_pulse_q ##1 cpu_hold_q);
  c_disable_seq: cover property (@(posedge sys_clk) disable iff (rst)
    wde_q && ce_q ##[1:4] !wde_q);
  c_kick_clears: cover property (@(posedge sys_clk) disable iff (rst)
    ((wdt_count_w != '0) && watchdog_restart_instruction) ##1 (wdt_count_w == '0));

endmodule : wdr_watchdog_top

// ==== wdr_far_model.sv ====
// Far-side model: free-running watchdog oscillator and external reset sources
`timescale 1ns/1ps

module wdr_far_model #(
  parameter int OSC_HALF_NS = 26
) (
  output logic wdt_osc,
  output logic brownout_rst,
  output logic pin_rst_n
);
  // ==========================================================
  // Oscillator
  // Odd start offset keeps its edges off the system clock edges
  initial begin
    wdt_osc = 1'b0;
    #7;
    forever #(OSC_HALF_NS) wdt_osc = ~wdt_osc;
  end

  // ==========================================================
  // Reset sources, idle inactive
  initial begin
    brownout_rst = 1'b0;
    pin_rst_n    = 1'b1;
  end

  // Hold one source active for a time, then release it
  task automatic hold_src(input logic brown, input int ns);
    if (brown) brownout_rst = 1'b1;
    else pin_rst_n = 1'b0;
    #(ns);
    brownout_rst = 1'b0;
    pin_rst_n    = 1'b1;
  endtask : hold_src
endmodule : wdr_far_model

// ==== tb_top.sv ====
// Self-checking bench of the watchdog and reset-cause block
`timescale 1ns/1ps

module tb_top;
  // ==========================================================
  // Signals
  logic       sys_clk;
  logic       rst;
  logic [3:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data_q;
  logic       kick_q;
  logic       wdt_osc;
  logic       brownout_rst;
  logic       pin_rst_n;
  logic       fuse_q;
  logic       wdt_rst_pulse_q;
  logic       cpu_hold_q;
  int         n_fail;
  int         samples_checked;
  int         n_pulse;
  int         cyc;
  int         n0;

  // Short base count keeps every time-out within a few thousand cycles
  wdr_watchdog_top #(.BASE_CYC(22'h000004), .STARTUP_CYC(16'h0040)) u_wdr_watchdog_top (
    .sys_clk                      (sys_clk),
    .rst                          (rst),
    .addr                         (addr),
    .wr_data                      (wr_data),
    .wr_en                        (wr_en),
    .rd_en                        (rd_en),
    .rd_data_q                    (rd_data_q),
    .watchdog_restart_instruction (kick_q),
    .wdt_osc                      (wdt_osc),
    .brownout_rst                 (brownout_rst),
    .pin_rst_n                    (pin_rst_n),
    .safety_level_fuse            (fuse_q),
    .wdt_rst_pulse_q              (wdt_rst_pulse_q),
    .cpu_hold_q                   (cpu_hold_q)
  );

  wdr_far_model u_wdr_far_model (
    .wdt_osc      (wdt_osc),
    .brownout_rst (brownout_rst),
    .pin_rst_n    (pin_rst_n)
  );

  // ==========================================================
  // Clock, pulse count and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Ceiling well above the roughly 5.4k cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (wdt_rst_pulse_q === 1'b1) n_pulse = n_pulse + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  // ==========================================================
  // Bus tasks; signals move 1 ns after the edge so strobes never clash
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(e, rd_data_q);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle

  task automatic kick();
    kick_q <= 1'b1;
    @(posedge sys_clk);
    kick_q <= 1'b0;
    #1;
  endtask : kick

  // ==========================================================
  // Compare tasks
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic chk_ok(input logic c);
    samples_checked = samples_checked + 1;
    if (c !== 1'b1) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, 1'b1, c);
    end
  endtask : chk_ok

  // Guarded period change, then time a full run to expiry and the hold
  task automatic tmo(input logic [2:0] p);
    int n;
    int e;
    e = 13 * (4 << p);
    wr(4'h1, 8'h18);
    wr(4'h1, {5'h01, p});
    rdchk(4'h1, {5'h01, p});
    kick();
    n = 0;
    while (wdt_rst_pulse_q !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n = n + 1;
    end
    chk_ok(n >= e - 13 && n <= e + 12);
    @(posedge sys_clk);
    #1;
    chk(8'h00, {7'h0, wdt_rst_pulse_q});
    chk(8'h01, {7'h0, cpu_hold_q});
    n = 0;
    while (cpu_hold_q === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n = n + 1;
    end
    chk_ok(n >= 62 && n <= 66);
    rdchk(4'h0, 8'h08);
    wr(4'h0, 8'h00);
  endtask : tmo

  task automatic end_sim();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Main sequence
  initial begin
    n_fail = 0;
    samples_checked = 0;
    n_pulse = 0;
    cyc = 0;
    rst = 1'b1;
    addr = 4'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    kick_q = 1'b0;
    fuse_q = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    idle(3);
    rdchk(4'h0, 8'h01);
    rdchk(4'h1, 8'h00);
    rdchk(4'h5, 8'h00);
    wr(4'h0, 8'hf1);
    rdchk(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    rdchk(4'h0, 8'h00);
    wr(4'h1, 8'he8);
    rdchk(4'h1, 8'h08);
    wr(4'h1, 8'h0b);
    rdchk(4'h1, 8'h08);
    wr(4'h1, 8'h00);
    rdchk(4'h1, 8'h08);
    // Change window edges: fifth cycle refused, fourth accepted
    wr(4'h1, 8'h18);
    idle(4);
    wr(4'h1, 8'h00);
    rdchk(4'h1, 8'h08);
    wr(4'h1, 8'h18);
    idle(3);
    wr(4'h1, 8'h00);
    rdchk(4'h1, 8'h00);
    n0 = n_pulse;
    idle(2000);
    chk_ok(n_pulse == n0);
    wr(4'h1, 8'h08);
    tmo(3'h0);
    tmo(3'h1);
    tmo(3'h3);
    // Restarts spaced below the time-out keep the chip alive
    n0 = n_pulse;
    for (int i = 0; i < 10; i++) begin
      kick();
      idle(200);
    end
    chk_ok(n_pulse == n0);
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h00);
    u_wdr_far_model.hold_src(1'b1, 200);
    idle(80);
    rdchk(4'h0, 8'h04);
    wr(4'h0, 8'h00);
    u_wdr_far_model.hold_src(1'b0, 200);
    idle(80);
    rdchk(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    rdchk(4'h0, 8'h00);
    // Programmed fuse forces the watchdog on and blocks its disable
    fuse_q <= 1'b1;
    idle(3);
    rdchk(4'h1, 8'h08);
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h01);
    rdchk(4'h1, 8'h09);
    n0 = n_pulse;
    idle(300);
    chk_ok(n_pulse > n0);
    fuse_q <= 1'b0;
    // Second power-on reset in mid-run
    rst <= 1'b1;
    idle(3);
    rst <= 1'b0;
    idle(3);
    rdchk(4'h0, 8'h01);
    rdchk(4'h1, 8'h00);
    end_sim();
  end
endmodule : tb_top
